// ---- mode_reg_prog.sv ----
// Mode-register programming path with APB control and status
//
// Notes on behaviour
// [RQ1] The register select goes out on the bank-select pins and the value on the row pins.
// [RQ2] User logic gives select and value together on addr in the command cycle.
// [RQ3] A written mode register reconfigures burst length and latencies of the controller.
// [RQ4] The value sits in the low addr bits, 11 bits for DDR and 13 for DDR2.
// [RQ5] The select is addr[12:11] for DDR, addr[14:13] for DDR2, codes 00 to 11.
// [RQ6] Address lines above the select are ignored when the command is taken.
// [RQ7] DDR supports only base and first extended registers, DDR2 all four.
// [RQ8] DDR base default is BL 4, sequential, CL 2, normal, DLL reset set, rest zero.
// [RQ9] DDR first extended default is DLL enabled, normal drive, rest zero.
// [RQ10] DDR2 base default is BL 4, sequential, CL 4, DLL reset, WR code 010, fast exit.
// [RQ11] DDR2 first extended default has AL code 011, DQS mode bit set, rest zero.
// [RQ12] DDR2 second extended register defaults to all zeros.
// [RQ13] DDR2 third extended register defaults to all zeros.
// [RQ14] Timing-related defaults are replaceable by build-time parameters.
// [RQ15] User logic encodes the load command as 0110; other codes are not ours.
// [RQ16] Command-ready pulses one cycle and a command is taken only with valid in it.
// [RQ17] The mode-register-set goes out with all strobes low only while banks are idle.
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "mode_reg_defines.svh"

module mode_reg_prog
   import mode_reg_pkg::*;
#(
   parameter logic [2:0] BL_INIT      = `DEF_BL,
   parameter logic [0:0] BT_INIT      = `DEF_BT,
   parameter logic [2:0] DDR_CL_INIT  = `DEF_DDR_CL,
   parameter logic [2:0] DDR2_CL_INIT = `DEF_DDR2_CL,
   parameter logic [2:0] WR_INIT      = `DEF_WR,
   parameter logic [0:0] PD_INIT      = `DEF_PD,
   parameter logic [1:0] RTT_INIT     = `DEF_RTT,
   parameter logic [2:0] AL_INIT      = `DEF_AL
)
(
   input  wire logic                         pclk,
   input  wire logic                         presetn,
   input  wire logic                         ce,
   input  wire logic                         psel,
   input  wire logic                         penable,
   input  wire logic                         pwrite,
   input  wire logic [`PADDR_WIDTH-1:0]      paddr,
   input  wire logic [31:0]                  pwdata,
   output logic      [31:0]                  prdata,
   output logic                              pready,
   output logic                              pslverr,
   output logic                              cmd_rdy,
   input  wire logic                         cmd_valid,
   input  wire logic [`CMD_WIDTH-1:0]        cmd,
   input  wire logic [`LOCAL_ADDR_WIDTH-1:0] addr,
   input  wire logic                         all_banks_idle,
   output logic                              mem_cs_n,
   output logic                              mem_ras_n,
   output logic                              mem_cas_n,
   output logic                              mem_we_n,
   output logic      [`BA_WIDTH-1:0]         mem_bank_select_out,
   output logic      [`ROW_WIDTH-1:0]        mem_row_address_out
);

   // ----------------------------------------------------------------
   // Power-up contents built from the parameters
   // ----------------------------------------------------------------
   localparam logic [`MR_WIDTH-1:0] DDR_MR_DEF  = {4'h0, `DEF_DLL_RESET, 1'b0,
      DDR_CL_INIT, BT_INIT, BL_INIT};                                   // [RQ8] [RQ14]
   localparam logic [`MR_WIDTH-1:0] DDR_EMR_DEF = `ZERO_MR;                // [RQ9]
   localparam logic [`MR_WIDTH-1:0] DDR2_MR_DEF = {PD_INIT, WR_INIT, `DEF_DLL_RESET,
      1'b0, DDR2_CL_INIT, BT_INIT, BL_INIT};                            // [RQ10] [RQ14]
   localparam logic [`MR_WIDTH-1:0] DDR2_EMR_DEF = {2'h0, `DEF_DQS_MODE, 3'h0,
      RTT_INIT[1], AL_INIT, RTT_INIT[0], 2'h0};                         // [RQ11] [RQ14]
   localparam logic [`MR_WIDTH-1:0] SLOT_RESET [4] = '{DDR2_MR_DEF, DDR2_EMR_DEF,
      `ZERO_MR, `ZERO_MR};                                              // [RQ12] [RQ13]

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   prog_state_t               state_reg;
   prog_state_t               state_next;
   logic                      ddr2_mode_reg;
   logic                      sel_err_reg;
   logic [1:0]                sel_reg;
   logic [`MR_WIDTH-1:0]      data_reg;
   logic [1:0]                addr_sel;
   logic [`MR_WIDTH-1:0]      addr_data;
   logic                      take_load, sel_ok, issue_now, addr_ok;
   logic                      apb_write, apb_read, ctrl_write, reload, reload_ddr2;
   logic [3:0]                slot_load;
   logic [`MR_WIDTH-1:0]      slot_value [4];
   logic [`MR_WIDTH-1:0]      def_value  [4];
   logic [3:0]                dec_bl, dec_cl, dec_al, dec_wr;
   logic [19:0]               cfg_reg;
   logic [31:0]               rd_mux;

   // ----------------------------------------------------------------
   // Command intake
   // ----------------------------------------------------------------
   // Select and value picked from fixed low lines, upper lines dropped
   assign addr_sel  = ddr2_mode_reg ? addr[`DDR2_SEL_HI:`DDR2_SEL_LO]
                                    : addr[`DDR_SEL_HI:`DDR_SEL_LO];   // [RQ5] [RQ6]
   assign addr_data = ddr2_mode_reg ? addr[`DDR2_DATA_HI:0]
                                    : {2'h0, addr[`DDR_DATA_HI:0]};    // [RQ4]
   // Ready is a single-cycle offer; only a valid load command is ours
   assign cmd_rdy   = ce && (state_reg == S_OFFER);                     // [RQ16]
   assign take_load = cmd_rdy && cmd_valid && (cmd == `CMD_LOAD_MODE_REG_COMMAND);    // [RQ15] [RQ16]
   assign sel_ok    = ddr2_mode_reg || !addr_sel[1];                    // [RQ7]
   assign issue_now = ce && (state_reg == S_WAIT) && all_banks_idle;    // [RQ17]

   // Next state
   always_comb
   begin
      unique case (state_reg)
         S_OFFER: state_next = (take_load && sel_ok) ? S_WAIT : S_HOLD;
         S_HOLD:  state_next = S_OFFER;
         S_WAIT:  state_next = all_banks_idle ? S_ISSUE : S_WAIT;      // [RQ17]
         S_ISSUE: state_next = S_OFFER;
         default: state_next = S_OFFER;
      endcase
   end

   // State register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         state_reg <= S_OFFER;
      else if (ce)
         state_reg <= state_next;
   end
   // Capture of select and value at the taking edge
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sel_reg  <= `SEL_BASE;
         data_reg <= `ZERO_MR;
      end
      else if (ce && take_load && sel_ok)
      begin
         sel_reg  <= addr_sel;
         data_reg <= addr_data;
      end
   end

   // ----------------------------------------------------------------
   // Memory command outputs
   // ----------------------------------------------------------------
   // Strobes low for one cycle; select on bank pins, value on row pins
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} <= 4'hF;
         mem_bank_select_out <= 3'h0;
         mem_row_address_out <= `ZERO_MR;
      end
      else if (ce)
      begin
         {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} <= {4{!issue_now}};  // [RQ17]
         if (issue_now)
         begin
            mem_bank_select_out <= {1'b0, sel_reg};                     // [RQ1]
            mem_row_address_out <= data_reg;                            // [RQ1]
         end
      end
   end

   // ----------------------------------------------------------------
   // Shadow registers and derived configuration
   // ----------------------------------------------------------------
   // Defaults per memory type for a reload
   always_comb
   begin
      def_value[0] = reload_ddr2 ? DDR2_MR_DEF  : DDR_MR_DEF;           // [RQ8] [RQ10]
      def_value[1] = reload_ddr2 ? DDR2_EMR_DEF : DDR_EMR_DEF;          // [RQ9] [RQ11]
      def_value[2] = `ZERO_MR;                                          // [RQ12]
      def_value[3] = `ZERO_MR;                                          // [RQ13]
   end

   // The slot written follows the register sent to memory
   assign slot_load = issue_now ? (4'h1 << sel_reg) : 4'h0;             // [RQ3]
   // One shadow slot per mode register, each with its own power-up value
   for (genvar g = 0; g < 4; g++)
   begin : g_slot
      mode_reg_slot #(.RESET_VALUE(SLOT_RESET[g])) u_slot (
         .pclk          (pclk),
         .presetn       (presetn),
         .ce            (ce),
         .load_default  (reload),
         .default_value (def_value[g]),
         .load          (slot_load[g]),
         .load_value    (data_reg),
         .value_reg     (slot_value[g])
      );
   end

   mode_reg_decode u_decode (
      .ddr2_mode        (ddr2_mode_reg),
      .base_value       (slot_value[0]),
      .ext1_value       (slot_value[1]),
      .burst_beats      (dec_bl),
      .cas_latency      (dec_cl),
      .additive_latency (dec_al),
      .write_recovery   (dec_wr)
   );
   // Controller settings follow the shadow registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cfg_reg <= 20'h0_0000;
      else if (ce)
         cfg_reg <= {dec_al + dec_cl, dec_wr, dec_al, dec_cl, dec_bl};  // [RQ3]
   end

   // ----------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------
   assign pready      = ce;
   assign apb_write   = psel && penable && pready && pwrite;
   assign apb_read    = psel && !penable && !pwrite;
   assign ctrl_write  = apb_write && (paddr == `REG_CTRL);
   assign reload_ddr2 = pwdata[`CTRL_DDR2_BIT];
   assign reload      = ctrl_write && (pwdata[`CTRL_RELOAD_BIT] ||
                        (pwdata[`CTRL_DDR2_BIT] != ddr2_mode_reg));
   assign addr_ok     = paddr inside {`REG_CTRL, `REG_STATUS, `REG_CONFIG, `REG_MR_BASE,
                                      `REG_MR_EXT1, `REG_MR_EXT2, `REG_MR_EXT3};
   assign pslverr     = psel && penable && !addr_ok;
   // Memory type control
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ddr2_mode_reg <= `CTRL_RESET_DDR2;
      else if (ce && ctrl_write)
         ddr2_mode_reg <= pwdata[`CTRL_DDR2_BIT];
   end

   // Sticky flag for an unsupported select; a new event beats the clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         sel_err_reg <= 1'b0;
      else if (ce && take_load && !sel_ok)                              // [RQ7]
         sel_err_reg <= 1'b1;
      else if (ce && apb_write && paddr == `REG_STATUS && pwdata[`STAT_SELERR_BIT])
         sel_err_reg <= 1'b0;
   end

   // Read data selected in the setup cycle
   always_comb
   begin
      unique case (paddr)
         `REG_CTRL:    rd_mux = {31'h0, ddr2_mode_reg};
         `REG_STATUS:  rd_mux = {30'h0, sel_err_reg, state_reg inside {S_WAIT, S_ISSUE}};
         `REG_CONFIG:  rd_mux = {12'h0, cfg_reg};
         `REG_MR_BASE: rd_mux = {19'h0, slot_value[0]};
         `REG_MR_EXT1: rd_mux = {19'h0, slot_value[1]};
         `REG_MR_EXT2: rd_mux = {19'h0, slot_value[2]};
         `REG_MR_EXT3: rd_mux = {19'h0, slot_value[3]};
         default:      rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (ce && apb_read)
         prdata <= rd_mux;
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_ready_pulse;
      cmd_rdy |=> !cmd_rdy;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse)                       // [RQ16]
      else $error("command ready held longer than one cycle");
   property p_wait_needs_take;
      $rose(state_reg == S_WAIT) |-> $past(cmd_rdy && cmd_valid);
   endproperty
   a_wait_needs_take: assert property (p_wait_needs_take)               // [RQ16]
      else $error("load started without a valid offer");
   property p_issue_idle;
      $fell(mem_cs_n) |-> $past(all_banks_idle) && !mem_ras_n && !mem_cas_n && !mem_we_n;
   endproperty
   a_issue_idle: assert property (p_issue_idle)                         // [RQ17]
      else $error("mode set issued with banks busy or strobes wrong");
   property p_issue_single;
      !mem_cs_n |=> mem_cs_n;
   endproperty
   a_issue_single: assert property (p_issue_single)                     // [RQ17]
      else $error("mode set longer than one cycle");
   property p_ddr2_map;
      (ce && take_load && ddr2_mode_reg) ##1 (ce && all_banks_idle) |=>
         !mem_cs_n && mem_row_address_out == $past(addr[12:0], 2) &&
         mem_bank_select_out[1:0] == $past(addr[14:13], 2);
   endproperty
   a_ddr2_map: assert property (p_ddr2_map)                              // [RQ1] [RQ4] [RQ5]
      else $error("DDR2 select or value wrong on memory pins");
   property p_ddr_map;
      (ce && take_load && !ddr2_mode_reg && !addr[12]) ##1 (ce && all_banks_idle) |=>
         !mem_cs_n && mem_row_address_out == {2'h0, $past(addr[10:0], 2)} &&
         mem_bank_select_out == {2'h0, $past(addr[11], 2)};
   endproperty
   a_ddr_map: assert property (p_ddr_map)                                // [RQ4] [RQ6]
      else $error("DDR select or value wrong on memory pins");
   property p_ddr_unsupported;
      ce && take_load && !ddr2_mode_reg && addr[12] |=> state_reg == S_HOLD && sel_err_reg;
   endproperty
   a_ddr_unsupported: assert property (p_ddr_unsupported)               // [RQ7]
      else $error("unsupported DDR register accepted");
   property p_reconfig;
      $fell(mem_cs_n) && mem_bank_select_out == 3'h0 |->
         slot_value[0] == mem_row_address_out ##1 cfg_reg[3:0] == dec_bl;
   endproperty
   a_reconfig: assert property (p_reconfig)                              // [RQ3]
      else $error("configuration not updated after mode set");
   property p_ddr_defaults;
      ce && reload && !reload_ddr2 |=> slot_value[0] == DDR_MR_DEF &&
         slot_value[1] == DDR_EMR_DEF;
   endproperty
   a_ddr_defaults: assert property (p_ddr_defaults)                     // [RQ8] [RQ9]
      else $error("DDR defaults not loaded");
   property p_ddr2_defaults;
      ce && reload && reload_ddr2 |=> slot_value[0] == DDR2_MR_DEF &&
         slot_value[1] == DDR2_EMR_DEF && slot_value[2] == 13'h0000 &&
         slot_value[3] == 13'h0000;
   endproperty
   a_ddr2_defaults: assert property (p_ddr2_defaults)                   // [RQ10] [RQ11] [RQ12] [RQ13]
      else $error("DDR2 defaults not loaded");
   c_load_taken: cover property (take_load && sel_ok);
   c_wait_banks: cover property (state_reg == S_WAIT ##1 state_reg == S_WAIT);
   c_ext3_issue: cover property ($fell(mem_cs_n) && mem_bank_select_out == 3'h3);
   c_sel_error:  cover property ($rose(sel_err_reg));

endmodule

// ---- mode_reg_defines.svh ----
// Constants for the mode-register programming block
`ifndef MODE_REG_DEFINES_SVH
`define MODE_REG_DEFINES_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define LOCAL_ADDR_WIDTH   29
`define ROW_WIDTH          13
`define BA_WIDTH           3
`define MR_WIDTH           13
`define DDR_DATA_BITS      11
`define CMD_WIDTH          4
`define PADDR_WIDTH        8

// ----------------------------------------------------------------
// Local address fields for mode programming
// ----------------------------------------------------------------
`define DDR_SEL_HI         12
`define DDR_SEL_LO         11
`define DDR2_SEL_HI        14
`define DDR2_SEL_LO        13
`define DDR_DATA_HI        10
`define DDR2_DATA_HI       12

// ----------------------------------------------------------------
// User command code and register select codes
// ----------------------------------------------------------------
`define CMD_LOAD_MODE_REG_COMMAND        4'h6
`define SEL_BASE           2'h0
`define SEL_EXT1           2'h1
`define SEL_EXT2           2'h2
`define SEL_EXT3           2'h3

// ----------------------------------------------------------------
// Power-up defaults
// ----------------------------------------------------------------
`define DEF_BL             3'h2
`define DEF_BT             1'h0
`define DEF_DDR_CL         3'h2
`define DEF_DDR2_CL        3'h4
`define DEF_WR             3'h2
`define DEF_PD             1'h0
`define DEF_RTT            2'h0
`define DEF_AL             3'h3
`define DEF_DLL_RESET      1'h1
`define DEF_DQS_MODE       1'h1
`define ZERO_MR            13'h0000

// ----------------------------------------------------------------
// Register offsets and fields (APB)
// ----------------------------------------------------------------
`define REG_CTRL           8'h00
`define REG_STATUS         8'h04
`define REG_CONFIG         8'h08
`define REG_MR_BASE        8'h10
`define REG_MR_EXT1        8'h14
`define REG_MR_EXT2        8'h18
`define REG_MR_EXT3        8'h1C
`define CTRL_DDR2_BIT      0
`define CTRL_RELOAD_BIT    1
`define STAT_BUSY_BIT      0
`define STAT_SELERR_BIT    1
`define CTRL_RESET_DDR2    1'h1

`endif

// ---- mode_reg_pkg.sv ----
// Types shared by the mode-register programming block
package mode_reg_pkg;

   // Command path states, one-hot
   typedef enum logic [3:0] {
      S_OFFER = 4'b0001,
      S_HOLD  = 4'b0010,
      S_WAIT  = 4'b0100,
      S_ISSUE = 4'b1000
   } prog_state_t;

endpackage

// ---- mode_reg_slot.sv ----
// One shadow copy of a memory mode register
`timescale 1ns/1ps
`include "mode_reg_defines.svh"

module mode_reg_slot
   import mode_reg_pkg::*;
#(
   parameter logic [`MR_WIDTH-1:0] RESET_VALUE = `ZERO_MR
)
(
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 ce,
   input  wire logic                 load_default,
   input  wire logic [`MR_WIDTH-1:0] default_value,
   input  wire logic                 load,
   input  wire logic [`MR_WIDTH-1:0] load_value,
   output logic      [`MR_WIDTH-1:0] value_reg
);

   // Default reload takes priority over a programmed value
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         value_reg <= RESET_VALUE;
      else if (ce && load_default)
         value_reg <= default_value;
      else if (ce && load)
         value_reg <= load_value;
   end

endmodule

// ---- mode_reg_decode.sv ----
// Turns mode register contents into controller timing settings
`timescale 1ns/1ps
`include "mode_reg_defines.svh"

module mode_reg_decode
   import mode_reg_pkg::*;
(
   input  wire logic                 ddr2_mode,
   input  wire logic [`MR_WIDTH-1:0] base_value,
   input  wire logic [`MR_WIDTH-1:0] ext1_value,
   output logic      [3:0]           burst_beats,
   output logic      [3:0]           cas_latency,
   output logic      [3:0]           additive_latency,
   output logic      [3:0]           write_recovery
);

   logic [2:0] bl_code;
   logic [2:0] cl_code;

   assign bl_code = base_value[2:0];
   assign cl_code = base_value[6:4];

   // Burst length and latencies from the field codes
   always_comb
   begin
      unique case (bl_code)
         3'h1:    burst_beats = 4'h2;
         3'h2:    burst_beats = 4'h4;
         3'h3:    burst_beats = 4'h8;
         default: burst_beats = 4'h4;
      endcase
      // Half-cycle DDR latency rounds up to the next whole cycle
      if (!ddr2_mode && cl_code == 3'h6)
         cas_latency = 4'h3;
      else
         cas_latency = {1'b0, cl_code};
      additive_latency = ddr2_mode ? {1'b0, ext1_value[5:3]} : 4'h0;
      write_recovery   = ddr2_mode ? ({1'b0, base_value[11:9]} + 4'h1) : 4'h0;
   end

endmodule

// ---- user_cmd_model.sv ----
// User-logic model that offers commands on the local command port
`timescale 1ns/1ps
module user_cmd_model
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        go,
   input  wire logic [3:0]  rq_cmd,
   input  wire logic [28:0] rq_addr,
   input  wire logic        cmd_rdy,
   output logic             cmd_valid,
   output logic [3:0]       cmd,
   output logic [28:0]      addr
);
   // Offer a command and hold it until a ready pulse takes it
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cmd_valid <= 1'b0;
         cmd       <= 4'h0;
         addr      <= 29'h0000_0000;
      end
      else if (go)
      begin
         cmd_valid <= 1'b1;
         cmd       <= rq_cmd;
         addr      <= rq_addr;  // Select and value in one word
      end
      else if (cmd_valid && cmd_rdy)
      begin
         cmd_valid <= 1'b0;
         cmd       <= ~cmd;     // Stale lines turn to junk
         addr      <= ~addr;
      end
   end
endmodule

// ---- test_mode_reg_prog.sv ----
// Self-checking bench for the mode-register programming block
`timescale 1ns/1ps
module test_mode_reg_prog import mode_reg_pkg::*;;
   logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, go, rerr;
   logic        cmd_rdy, cmd_valid, all_banks_idle, mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, r;
   logic [3:0]  cmd, rq_cmd;
   logic [28:0] addr, rq_addr;
   logic [2:0]  mem_bank_select_out;
   logic [12:0] mem_row_address_out;
   logic [12:0] vals [4] = '{13'h0053, 13'h1ABC, 13'h0F0F, 13'h1555};
   int          fail_count = 0;
   int          n_compared = 0;

   mode_reg_prog #(.BL_INIT(3'h3)) dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .cmd_rdy, .cmd_valid, .cmd, .addr,
      .all_banks_idle, .mem_cs_n, .mem_ras_n, .mem_cas_n, .mem_we_n, .mem_bank_select_out,
      .mem_row_address_out);
   user_cmd_model umodel (.pclk, .presetn, .go, .rq_cmd, .rq_addr, .cmd_rdy, .cmd_valid,
      .cmd, .addr);

   // Clock and watchdog
   initial
   begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   initial
   begin
      repeat (5000) @(posedge pclk);
      fail_count++;
      report_and_stop();
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] e);
      n_compared++;
      if (got !== e)
      begin
         fail_count++;
         $display("ERROR t=%0t got %h exp %h", $time, got, e);
      end
   endtask

   // APB transfer: setup, access until pready, then release
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk) penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      chk(r, e);
   endtask

   task automatic send(input logic [3:0] c, input logic [28:0] a);
      go <= 1'b1;
      rq_cmd <= c;
      rq_addr <= a;
      @(posedge pclk) go <= 1'b0;
   endtask

   // Wait a bounded time for a mode set, then compare strobes, bank and row
   task automatic watch(input logic [19:0] e);
      int n;
      n = 0;
      do @(posedge pclk); while (mem_cs_n !== 1'b0 && ++n < 20);
      chk({12'h000, mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n, mem_bank_select_out,
           mem_row_address_out}, {12'h000, e});
      @(posedge pclk);
   endtask

   task automatic report_and_stop();
      if (fail_count == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Main sequence
   initial
   begin
      {ce, psel, penable, pwrite, go, all_banks_idle, presetn} = 7'b1000010;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      rq_cmd = 4'h0;
      rq_addr = 29'h0000_0000;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(8'h10, 32'h0000_0543);
      rd(8'h14, 32'h0000_0418);
      rd(8'h18, 32'h0000_0000);
      rd(8'h1C, 32'h0000_0000);
      for (int s = 0; s < 4; s++)
      begin
         send(4'h6, {14'h3FFF, s[1:0], vals[s]});
         watch({4'h0, 1'b0, s[1:0], vals[s]});
         rd(8'h10 + 8'(4 * s), {19'h0_0000, vals[s]});
      end
      apb(1'b0, 8'h08, 32'h0000_0000);
      chk({24'h00_0000, r[7:0]}, 32'h0000_0058);
      all_banks_idle <= 1'b0;
      send(4'h6, {16'h0000, 13'h0ACE});
      watch({4'hF, 3'h3, vals[3]});
      all_banks_idle <= 1'b1;
      watch({4'h0, 3'h0, 13'h0ACE});
      send(4'h1, {16'h0000, 13'h1111});
      watch({4'hF, 3'h0, 13'h0ACE});
      apb(1'b1, 8'h00, 32'h0000_0000);
      rd(8'h10, 32'h0000_0123);
      rd(8'h14, 32'h0000_0000);
      rd(8'h1C, 32'h0000_0000);
      send(4'h6, {16'hFFFF, 2'b01, 11'h5A5});
      watch({4'h0, 3'h1, 13'h05A5});
      send(4'h6, {16'h0000, 2'b10, 11'h123});
      watch({4'hF, 3'h1, 13'h05A5});
      rd(8'h04, 32'h0000_0002);
      apb(1'b1, 8'h04, 32'h0000_0002);
      rd(8'h04, 32'h0000_0000);
      apb(1'b1, 8'h00, 32'h0000_0003);
      rd(8'h10, 32'h0000_0543);
      rd(8'h14, 32'h0000_0418);
      apb(1'b0, 8'h0C, 32'h0000_0000);
      chk({r[31:1], rerr}, 32'h0000_0001); // Unmapped offset flags an error
      report_and_stop();
   end
endmodule
